// [cmbi_acc_if.sv]
/*
  Access channel between one operation splitter and the bus hub.
  Assumes hub answers ack combinationally in the cycle it takes an access.
*/
`timescale 1ns/10ps
interface cmbi_acc_if;
  logic req;
  logic we;
  logic wide;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic cap16;
  logic ack;
  logic [15:0] rdata;

  modport split (output req, we, wide, addr, wdata, input cap16, ack, rdata);
  modport hub (input req, we, wide, addr, wdata, output cap16, ack, rdata);
endinterface

// [cmbi_mem_model.sv]
/*
  Model of the four memory buses: one byte array per bus, 256 bytes each.
  Assumes the design holds each strobe and its qualifiers until rdy.
*/
`timescale 1ns/10ps
module cmbi_mem_model (
  input wire logic mclk_in,
  input wire logic slow_in,
  input wire logic ext_bus16_in,
  input wire logic [3:0] bus_req_in,
  input wire logic [3:0] bus_we_in,
  input wire logic [3:0] bus_wide_in,
  input wire logic [3:0][23:0] bus_addr_in,
  input wire logic [3:0][15:0] bus_wdata_in,
  output logic [3:0][15:0] bus_rdata_out,
  output logic [3:0] bus_rdy_out,
  output logic io_present_out,
  output logic io_wide_out
);
  logic [7:0] mem [4][256];
  logic tick_r = 1'b0;
  logic [15:0] junk_r = 16'h5A3C;
  ////////////////////////////////////////
  // io page from 0x100 absent; upper half of a page is an 8-bit peripheral
  assign io_present_out = ~bus_addr_in[2][8];
  assign io_wide_out = ~bus_addr_in[2][7];
  // answer at once or every other cycle; junk when not selected
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bus_rdy_out[b] = bus_req_in[b] & (~slow_in | tick_r);
      bus_rdata_out[b] = junk_r;
      // a 16-bit access on an 8-bit bus gets byte lanes only
      if (bus_req_in[b] && bus_wide_in[b]
          && (b == 3 ? ext_bus16_in : b == 2 ? io_wide_out : 1'b1)) begin
        bus_rdata_out[b] = {mem[b][{bus_addr_in[b][7:1], 1'b0}], mem[b][{bus_addr_in[b][7:1], 1'b1}]};
      end else if (bus_req_in[b]) begin
        bus_rdata_out[b] = {2{mem[b][bus_addr_in[b][7:0]]}};
      end
    end
  end
  // store written bytes, even byte of a word on the upper lane
  always @(posedge mclk_in) begin
    tick_r <= ~tick_r;
    junk_r <= junk_r + 16'h3B1D;
    for (int b = 0; b < 4; b++) begin
      if (bus_req_in[b] && bus_rdy_out[b] && bus_we_in[b] && bus_wide_in[b]) begin
        mem[b][{bus_addr_in[b][7:1], 1'b0}] <= bus_wdata_in[b][15:8];
        mem[b][{bus_addr_in[b][7:1], 1'b1}] <= bus_wdata_in[b][7:0];
      end else if (bus_req_in[b] && bus_rdy_out[b] && bus_we_in[b]) begin
        mem[b][bus_addr_in[b][7:0]] <= bus_wdata_in[b][7:0];
      end
    end
  end
endmodule

// [cmbi_params.svh]
/*
  Constants of the CPU memory bus interface: address map, control register
  layout, reset values and the low vector block of non-volatile memory.
  Assumes it is included once per compilation unit by its bare name.
*/
// Functional notes
// - bandwidth field 00 lets DMA take every bus cycle it requests.
// - fields 01, 10, 11 allow one DMA transaction per one, two, three CPU operations.
// - bandwidth field bits [1:0] read/write; bits [7:2] read-only reserved.
// - fetch path and execution path may use two different buses at once.
// - addresses carried as 32 bits, only low 24 bits decoded.
// - 16-bit addresses sign-extended to lowest and highest 32 KB.
// - anything not non-volatile, RAM or I/O goes to external memory.
// - non-volatile memory low block holds option bits, then vectors.
// - 8 KB I/O region sits at the top of the 24-bit space.
// - unimplemented I/O reads return all ones; writes change nothing.
// - multi-byte data big-endian, most significant byte at the address.
// - non-volatile memory and RAM 16 bits wide; peripherals 8 or 16.
// - external memory port configurable as 8-bit or 16-bit.
// - 16-bit memory, even address: word in one access, quad in two.
// - 16-bit memory, odd address: word in two accesses, quad in three.
`ifndef CMBI_PARAMS_SVH
`define CMBI_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// control register
`define CMBI_CTL_OFFSET 32'hFFFFE012
`define CMBI_CTL_RESET 8'hFF
`define CMBI_CTL_RSVD 6'h3F
`define CMBI_BW_MSB 1
`define CMBI_BW_LSB 0
`define CMBI_BW_RESET 2'h3

////////////////////////////////////////////////////////////////////////////////
// address map
`define CMBI_IO_TAG 11'h7FF
`define CMBI_IO_TAG_LSB 13
`define CMBI_UNIMPL_BYTE 8'hFF
`define CMBI_OPTION_ADDR 24'h000000
`define CMBI_RESET_VEC_ADDR 24'h000004
`define CMBI_SYSEXC_VEC_ADDR 24'h000008
`define CMBI_IRQ_VEC_LAST 24'h00006F

`endif

// [cmbi_pkg.sv]
/*
  Types shared by the bus interface modules: bus selectors, operation sizes
  and splitter states. Assumes nothing beyond a SystemVerilog compiler.
*/
package cmbi_pkg;

  // memory bus selector, also index into the bus port arrays
  typedef enum logic [1:0] {
    CMBI_BUS_NVM = 2'h0,
    CMBI_BUS_RAM = 2'h1,
    CMBI_BUS_IO = 2'h2,
    CMBI_BUS_EXT = 2'h3
  } cmbi_bus_t;

  // operation size, value is the byte count
  typedef enum logic [2:0] {
    CMBI_SZ_BYTE = 3'h1,
    CMBI_SZ_WORD = 3'h2,
    CMBI_SZ_QUAD = 3'h4
  } cmbi_size_t;

  typedef enum logic [0:0] {
    CMBI_ST_IDLE = 1'h0,
    CMBI_ST_ACC = 1'h1
  } cmbi_state_t;

endpackage

// [cmbi_split.sv]
/*
  Operation splitter: turns one byte, word or quad operation into byte and
  aligned 16-bit accesses on the access channel, in ascending address order.
  Assumes the hub reports the addressed bus width on cap16.
*/
`timescale 1ns/10ps
`include "cmbi_params.svh"
module cmbi_split import cmbi_pkg::*; (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic op_valid_in,
  input wire logic op_we_in,
  input wire cmbi_size_t op_size_in,
  input wire logic [31:0] op_addr_in,
  input wire logic op_short_in,
  input wire logic [31:0] op_wdata_in,
  output logic op_ready_out,
  output logic op_done_out,
  output logic [31:0] op_rdata_out,
  cmbi_acc_if.split acc
);

  cmbi_state_t state_r, state_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [2:0] rem_r, rem_nxt;
  logic we_r, we_nxt;
  logic [31:0] wbuf_r, wbuf_nxt;
  logic [31:0] rbuf_r, rbuf_nxt;
  logic done_r, done_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wide;
  logic [7:0] lane;

  ////////////////////////////////////////////////////////////////////////////
  // access shape: 16-bit only on wide bus, even address, two bytes left
  assign wide = acc.cap16 && !addr_r[0] && (rem_r >= 3'h2);
  assign lane = (acc.cap16 && !addr_r[0]) ? acc.rdata[15:8] : acc.rdata[7:0];
  assign acc.req = (state_r == CMBI_ST_ACC);
  assign acc.we = we_r;
  assign acc.wide = wide;
  assign acc.addr = addr_r;
  assign acc.wdata = wide ? wbuf_r[31:16] : {wbuf_r[31:24], wbuf_r[31:24]};
  assign op_ready_out = (state_r == CMBI_ST_IDLE);
  assign op_done_out = done_r;
  assign op_rdata_out = rdata_r;

  // next state of the splitter
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    rem_nxt = rem_r;
    we_nxt = we_r;
    wbuf_nxt = wbuf_r;
    rbuf_nxt = rbuf_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      CMBI_ST_IDLE: begin
        if (op_valid_in) begin
          state_nxt = CMBI_ST_ACC;
          // short addresses sign-extend, long ones drop bits 31:24
          addr_nxt = op_short_in ? {{8{op_addr_in[15]}}, op_addr_in[15:0]}
                                 : op_addr_in[23:0];
          rem_nxt = op_size_in;
          we_nxt = op_we_in;
          rbuf_nxt = 32'h00000000;
          // msb first: left-justify the write data
          case (op_size_in)
            CMBI_SZ_BYTE: wbuf_nxt = {op_wdata_in[7:0], 24'h000000};
            CMBI_SZ_WORD: wbuf_nxt = {op_wdata_in[15:0], 16'h0000};
            default: wbuf_nxt = op_wdata_in;
          endcase
        end
      end
      CMBI_ST_ACC: begin
        if (acc.ack) begin
          if (wide) begin
            rbuf_nxt = {rbuf_r[15:0], acc.rdata};
            wbuf_nxt = {wbuf_r[15:0], 16'h0000};
            addr_nxt = addr_r + 24'h000002;
            rem_nxt = rem_r - 3'h2;
          end else begin
            rbuf_nxt = {rbuf_r[23:0], lane};
            wbuf_nxt = {wbuf_r[23:0], 8'h00};
            addr_nxt = addr_r + 24'h000001;
            rem_nxt = rem_r - 3'h1;
          end
          if (rem_nxt == 3'h0) begin
            state_nxt = CMBI_ST_IDLE;
            done_nxt = 1'b1;
            rdata_nxt = rbuf_nxt;
          end
        end
      end
      default: state_nxt = CMBI_ST_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= CMBI_ST_IDLE;
      addr_r <= 24'h000000;
      rem_r <= 3'h0;
      we_r <= 1'b0;
      wbuf_r <= 32'h00000000;
      rbuf_r <= 32'h00000000;
      done_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      rem_r <= rem_nxt;
      we_r <= we_nxt;
      wbuf_r <= wbuf_nxt;
      rbuf_r <= rbuf_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks: access counts per operation, byte order and address forming
  logic [2:0] n_acc_r;
  logic any16_r;
  logic all16_r;
  logic odd_r;
  logic [2:0] size_r;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      n_acc_r <= 3'h0;
      any16_r <= 1'b0;
      all16_r <= 1'b0;
      odd_r <= 1'b0;
      size_r <= 3'h0;
    end else if (op_ready_out && op_valid_in) begin
      n_acc_r <= 3'h0;
      any16_r <= 1'b0;
      all16_r <= 1'b1;
      odd_r <= op_short_in ? op_addr_in[0] : op_addr_in[0];
      size_r <= op_size_in;
    end else if (acc.req && acc.ack) begin
      n_acc_r <= n_acc_r + 3'h1;
      any16_r <= any16_r | acc.cap16;
      all16_r <= all16_r & acc.cap16;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  chk_acc_count16: assert property (op_done_out && all16_r |->
    n_acc_r == ((size_r == 3'h1) ? 3'h1 : (size_r == 3'h2) ? (odd_r ? 3'h2 : 3'h1)
                                        : (odd_r ? 3'h3 : 3'h2)))
    else $error("wrong access count on 16-bit memory");
  chk_acc_count8: assert property (op_done_out && !any16_r |-> n_acc_r == size_r)
    else $error("wrong byte access count on 8-bit memory");
  chk_byte_order: assert property (acc.req && acc.ack && rem_r > 3'h1 && !wide
    |=> acc.req && acc.addr == $past(acc.addr) + 24'h000001)
    else $error("byte accesses not ascending");
  chk_short_addr: assert property (op_ready_out && op_valid_in && op_short_in
    |=> acc.addr == {{8{$past(op_addr_in[15])}}, $past(op_addr_in[15:0])})
    else $error("short address not sign extended");
  chk_addr_low: assert property (op_ready_out && op_valid_in && !op_short_in
    |=> acc.addr == $past(op_addr_in[23:0]))
    else $error("long address not cut to 24 bits");
endmodule

// [cmbi_top.sv]
/*
  CPU memory bus interface: two splitters (fetch, execution), a 24-bit
  address decoder onto four memory buses, the CPU control register and the
  DMA bandwidth throttle. Assumes memories answer on bus_rdy_in in the cycle
  of the request or later, with the even byte of a 16-bit word on [15:8],
  and that peripherals report presence and width of the I/O bus address.
*/
`timescale 1ns/10ps
`include "cmbi_params.svh"
module cmbi_top import cmbi_pkg::*; #(
  parameter logic [23:0] NVM_SIZE = 24'h010000,
  parameter logic [23:0] RAM_BASE = 24'hFFB000,
  parameter logic [23:0] RAM_SIZE = 24'h002000
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic fetch_valid_in,
  input wire cmbi_size_t fetch_size_in,
  input wire logic [31:0] fetch_addr_in,
  input wire logic fetch_short_in,
  output logic fetch_ready_out,
  output logic fetch_done_out,
  output logic [31:0] fetch_rdata_out,
  input wire logic exe_valid_in,
  input wire logic exe_we_in,
  input wire cmbi_size_t exe_size_in,
  input wire logic [31:0] exe_addr_in,
  input wire logic exe_short_in,
  input wire logic [31:0] exe_wdata_in,
  output logic exe_ready_out,
  output logic exe_done_out,
  output logic [31:0] exe_rdata_out,
  output logic [3:0] bus_req_out,
  output logic [3:0] bus_we_out,
  output logic [3:0] bus_wide_out,
  output logic [3:0][23:0] bus_addr_out,
  output logic [3:0][15:0] bus_wdata_out,
  input wire logic [3:0][15:0] bus_rdata_in,
  input wire logic [3:0] bus_rdy_in,
  input wire logic io_present_in,
  input wire logic io_wide_in,
  input wire logic ext_bus16_in,
  input wire logic dma_req_in,
  output logic dma_gnt_out,
  output logic [1:0] dma_bandwidth_select_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode: I/O on top 8 KB, NVM from zero, RAM window, rest external
  function automatic cmbi_bus_t region(input logic [23:0] a);
    if (a[23:`CMBI_IO_TAG_LSB] == `CMBI_IO_TAG) begin
      region = CMBI_BUS_IO;
    end else if (a < NVM_SIZE) begin
      region = CMBI_BUS_NVM;
    end else if (a >= RAM_BASE && a - RAM_BASE < RAM_SIZE) begin
      region = CMBI_BUS_RAM;
    end else begin
      region = CMBI_BUS_EXT;
    end
  endfunction

  cmbi_acc_if acc[2] ();
  logic [1:0] a_req;
  logic [1:0] a_we;
  logic [1:0] a_wide;
  logic [1:0] a_ack;
  logic [1:0] a_cap;
  logic [1:0] a_won;
  logic [1:0][23:0] a_addr;
  logic [1:0][15:0] a_wdata;
  logic [1:0][15:0] a_rdata;
  cmbi_bus_t a_bus [2];
  logic [3:0] own_exe;
  logic [3:0] own_fet;
  logic io_sel;
  logic ctl_hit;
  logic io_local;
  logic [15:0] local_rdata;
  logic [7:0] ctl_rd;
  logic [1:0] bw_r, bw_nxt;
  logic [1:0] dcnt_r, dcnt_nxt;
  logic [2:0] dsum;
  logic dma_allow;
  // control register address, only the low 24 bits take part in the compare
  localparam logic [31:0] CTL_ADDR = `CMBI_CTL_OFFSET;

  // splitters: fetch reads only, execution reads and writes
  cmbi_split u_fetch (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .op_valid_in(fetch_valid_in),
    .op_we_in(1'b0),
    .op_size_in(fetch_size_in),
    .op_addr_in(fetch_addr_in),
    .op_short_in(fetch_short_in),
    .op_wdata_in(32'h00000000),
    .op_ready_out(fetch_ready_out),
    .op_done_out(fetch_done_out),
    .op_rdata_out(fetch_rdata_out),
    .acc(acc[0])
  );

  cmbi_split u_exe (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .op_valid_in(exe_valid_in),
    .op_we_in(exe_we_in),
    .op_size_in(exe_size_in),
    .op_addr_in(exe_addr_in),
    .op_short_in(exe_short_in),
    .op_wdata_in(exe_wdata_in),
    .op_ready_out(exe_ready_out),
    .op_done_out(exe_done_out),
    .op_rdata_out(exe_rdata_out),
    .acc(acc[1])
  );

  // channel signals into plain arrays
  for (genvar r = 0; r < 2; r++) begin : g_chan
    assign a_req[r] = acc[r].req;
    assign a_we[r] = acc[r].we;
    assign a_wide[r] = acc[r].wide;
    assign a_addr[r] = acc[r].addr;
    assign a_wdata[r] = acc[r].wdata;
    assign a_bus[r] = region(acc[r].addr);
    assign acc[r].ack = a_ack[r];
    assign acc[r].cap16 = a_cap[r];
    assign acc[r].rdata = a_rdata[r];
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bus ownership: execution wins a shared bus, others run in parallel
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      own_exe[b] = a_req[1] && (a_bus[1] == cmbi_bus_t'(b));
      own_fet[b] = a_req[0] && (a_bus[0] == cmbi_bus_t'(b)) && !own_exe[b];
    end
  end

  // local answers on the I/O bus: control register and absent addresses
  assign io_sel = own_exe[CMBI_BUS_IO];
  assign ctl_hit = (a_addr[io_sel] == CTL_ADDR[23:0]);
  assign io_local = ctl_hit || !io_present_in;
  assign ctl_rd = {`CMBI_CTL_RSVD, bw_r};
  assign local_rdata = ctl_hit ? {ctl_rd, `CMBI_UNIMPL_BYTE}
                               : {`CMBI_UNIMPL_BYTE, `CMBI_UNIMPL_BYTE};

  // bus outputs carry the owner's access; local I/O answers never strobe
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bus_addr_out[b] = own_exe[b] ? a_addr[1] : a_addr[0];
      bus_wdata_out[b] = own_exe[b] ? a_wdata[1] : a_wdata[0];
      bus_we_out[b] = own_exe[b] ? a_we[1] : a_we[0];
      bus_wide_out[b] = own_exe[b] ? a_wide[1] : a_wide[0];
      bus_req_out[b] = (own_exe[b] || own_fet[b]) && !dma_gnt_out;
    end
    if (io_local) begin
      bus_req_out[CMBI_BUS_IO] = 1'b0;
    end
  end

  // answers back to each splitter, with the width of the addressed bus
  always_comb begin
    a_won[1] = a_req[1] && !dma_gnt_out;
    a_won[0] = a_req[0] && !dma_gnt_out && !own_exe[a_bus[0]];
    for (int r = 0; r < 2; r++) begin
      case (a_bus[r])
        CMBI_BUS_NVM, CMBI_BUS_RAM: begin
          a_cap[r] = 1'b1;
          a_ack[r] = a_won[r] && bus_rdy_in[a_bus[r]];
          a_rdata[r] = bus_rdata_in[a_bus[r]];
        end
        CMBI_BUS_IO: begin
          a_cap[r] = io_local ? 1'b1 : io_wide_in;
          a_ack[r] = a_won[r] && (io_local || bus_rdy_in[CMBI_BUS_IO]);
          a_rdata[r] = io_local ? local_rdata : bus_rdata_in[CMBI_BUS_IO];
        end
        default: begin
          a_cap[r] = ext_bus16_in;
          a_ack[r] = a_won[r] && bus_rdy_in[CMBI_BUS_EXT];
          a_rdata[r] = bus_rdata_in[CMBI_BUS_EXT];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register write and DMA throttle count
  always_comb begin
    bw_nxt = bw_r;
    // only the bandwidth bits take writes, upper bits stay fixed
    if (io_sel && a_ack[1] && a_we[1] && ctl_hit) begin
      bw_nxt = a_wdata[1][8 + `CMBI_BW_MSB:8 + `CMBI_BW_LSB];
    end
    dsum = {1'b0, dcnt_r} + {2'h0, fetch_done_out} + {2'h0, exe_done_out};
    if (dma_gnt_out) begin
      dcnt_nxt = 2'h0;
    end else if (dsum > 3'h3) begin
      dcnt_nxt = 2'h3;
    end else begin
      dcnt_nxt = dsum[1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      bw_r <= `CMBI_BW_RESET;
      dcnt_r <= 2'h3;
    end else begin
      bw_r <= bw_nxt;
      dcnt_r <= dcnt_nxt;
    end
  end

  // grant: free when field is zero, else after enough CPU operations
  assign dma_allow = (bw_r == 2'h0) || (dcnt_r >= bw_r);
  assign dma_gnt_out = dma_req_in && dma_allow;
  assign dma_bandwidth_select_out = bw_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_ctl_write;
    io_sel && a_ack[1] && a_we[1] && ctl_hit;
  endsequence

  chk_dma_full: assert property (dma_req_in && bw_r == 2'h0 |-> dma_gnt_out)
    else $error("dma refused with full bandwidth");
  chk_dma_ratio: assert property (dma_gnt_out && bw_r != 2'h0
    |-> dcnt_r >= bw_r ##1 dcnt_r == 2'h0)
    else $error("dma granted too early");
  chk_dma_count: assert property (!dma_gnt_out && exe_done_out && dcnt_r == 2'h0
    |=> dcnt_r != 2'h0)
    else $error("cpu operation not counted");
  chk_ctl_write: assert property (s_ctl_write |=>
    bw_r == $past(a_wdata[1][9:8]) && ctl_rd[7:2] == `CMBI_CTL_RSVD)
    else $error("control register write lost");
  chk_dual_bus: assert property (a_req[0] && a_req[1] && a_bus[0] != a_bus[1]
    && !dma_gnt_out && a_bus[0] != CMBI_BUS_IO && a_bus[1] != CMBI_BUS_IO
    |-> bus_req_out[a_bus[0]] && bus_req_out[a_bus[1]])
    else $error("fetch and execution not served together");
  chk_io_unimpl: assert property (a_req[1] && a_bus[1] == CMBI_BUS_IO && !io_present_in
    && !ctl_hit |-> !bus_req_out[CMBI_BUS_IO] && a_rdata[1] == 16'hFFFF)
    else $error("unimplemented io not answered locally");
  chk_vec_nvm: assert property (a_req[1] && a_addr[1] <= `CMBI_IRQ_VEC_LAST
    |-> a_bus[1] == CMBI_BUS_NVM)
    else $error("vector block not in nvm");
endmodule

// [cmbi_top_test.sv]
/*
  Self-checking bench of the bus interface with random and corner ops.
  Assumes the memory model answers every bus of the design.
*/
`timescale 1ns/10ps
module cmbi_top_test;
  import cmbi_pkg::*;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic fetch_valid_in = 1'b0;
  cmbi_size_t fetch_size_in = CMBI_SZ_BYTE;
  logic [31:0] fetch_addr_in = 32'h0;
  logic fetch_short_in = 1'b0;
  logic exe_valid_in = 1'b0;
  logic exe_we_in = 1'b0;
  cmbi_size_t exe_size_in = CMBI_SZ_BYTE;
  logic [31:0] exe_addr_in = 32'h0;
  logic exe_short_in = 1'b0;
  logic [31:0] exe_wdata_in = 32'h0;
  logic ext_bus16_in = 1'b0;
  logic dma_req_in = 1'b0;
  logic slow_in = 1'b0;
  logic fetch_ready_out, fetch_done_out, exe_ready_out, exe_done_out, dma_gnt_out;
  logic io_present_in, io_wide_in;
  logic [31:0] fetch_rdata_out, exe_rdata_out;
  logic [3:0] bus_req_out, bus_we_out, bus_wide_out, bus_rdy_in;
  logic [3:0][23:0] bus_addr_out;
  logic [3:0][15:0] bus_wdata_out, bus_rdata_in;
  logic [1:0] dma_bandwidth_select_out;
  int bad_count = 0;
  int checks = 0;
  int acc[4];
  int gnts = 0;
  int cyc = 0;
  int seed = 55014;

  cmbi_top i_dut (.mclk_in, .srst_in, .fetch_valid_in, .fetch_size_in, .fetch_addr_in,
    .fetch_short_in, .fetch_ready_out, .fetch_done_out, .fetch_rdata_out, .exe_valid_in,
    .exe_we_in, .exe_size_in, .exe_addr_in, .exe_short_in, .exe_wdata_in, .exe_ready_out,
    .exe_done_out, .exe_rdata_out, .bus_req_out, .bus_we_out, .bus_wide_out, .bus_addr_out,
    .bus_wdata_out, .bus_rdata_in, .bus_rdy_in, .io_present_in, .io_wide_in, .ext_bus16_in,
    .dma_req_in, .dma_gnt_out, .dma_bandwidth_select_out);
  cmbi_mem_model i_mem (.mclk_in(mclk_in), .slow_in(slow_in), .ext_bus16_in(ext_bus16_in),
    .bus_req_in(bus_req_out), .bus_we_in(bus_we_out), .bus_wide_in(bus_wide_out),
    .bus_addr_in(bus_addr_out), .bus_wdata_in(bus_wdata_out), .bus_rdata_out(bus_rdata_in),
    .bus_rdy_out(bus_rdy_in), .io_present_out(io_present_in), .io_wide_out(io_wide_in));

  ////////////////////////////////////////
  // clock and run limit
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  // count accesses per bus and grant cycles, cut a hang short
  always @(posedge mclk_in) begin
    cyc++;
    for (int b = 0; b < 4; b++) acc[b] += (bus_req_out[b] & bus_rdy_in[b]);
    gnts += dma_gnt_out;
    if (dma_gnt_out === 1'b1) chk(bus_req_out, 0, "strobe in grant");
    if (cyc == 50000) begin
      bad_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // accesses for sz bytes from a on a 16-bit or 8-bit memory
  function automatic int nacc(input int sz, input logic [23:0] a, input bit w16);
    return !w16 ? sz : (a[0] && sz > 1) ? sz / 2 + 1 : (sz + 1) / 2;
  endfunction
  // who bit 1 starts the execution path, bit 0 the fetch path
  task automatic op(input bit [1:0] who, input bit we, input cmbi_size_t sz,
    input logic [31:0] a, input logic [31:0] fa, input bit sh, input logic [31:0] wd,
    output logic [31:0] rd, output logic both);
    int n;
    @(negedge mclk_in);
    acc = '{0, 0, 0, 0};
    fetch_size_in = sz;
    exe_size_in = sz;
    {exe_addr_in, fetch_addr_in} = {a, fa};
    {fetch_short_in, exe_short_in} = {sh, sh};
    {exe_we_in, exe_wdata_in} = {we, wd};
    {exe_valid_in, fetch_valid_in} = who;
    @(negedge mclk_in);
    {exe_valid_in, fetch_valid_in} = 2'b00;
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while ((who[1] ? exe_done_out : fetch_done_out) !== 1'b1 && n < 200);
    rd = who[1] ? exe_rdata_out : fetch_rdata_out;
    both = exe_done_out & fetch_done_out;
    chk(who[1] ? exe_ready_out : fetch_ready_out, 1, "ready at done");
    chk(n < 200, 1, "op done");
  endtask
  task automatic end_of_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] r, wd, rd, x;
    logic [23:0] a;
    logic both;
    int bs;
    cmbi_size_t sz;
    repeat (10) @(negedge mclk_in);
    srst_in = 1'b0;
    chk(dma_bandwidth_select_out, 3, "field reset");
    op(2, 0, CMBI_SZ_BYTE, 32'hFFFFE012, 0, 0, 0, rd, both);
    chk(rd[7:0], 8'hFF, "control reset");
    // random ops on nvm, ram and external memory
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      wd = $random(seed);
      bs = (r[1:0] == 2'h2) ? 3 : r[1:0];
      sz = (r[3:2] == 2'h0) ? CMBI_SZ_BYTE : r[3] ? CMBI_SZ_QUAD : CMBI_SZ_WORD;
      a = (bs == 0 ? 24'h000100 : bs == 1 ? 24'hFFB100 : 24'h200000) + (r[11:4] & 8'hEF);
      ext_bus16_in = r[13];
      slow_in = r[14];
      x = r[12] && bs == 1 ? {r[31:16], a[15:0]} : {r[31:24], a};
      op(2, 1, sz, x, 0, r[12] && bs == 1, wd, rd, both);
      chk(acc[bs], nacc(int'(sz), a, bs != 3 || ext_bus16_in), "write count");
      for (int k = 0; k < int'(sz); k++) begin
        chk(i_mem.mem[bs][8'(a[7:0] + k)], (wd >> (8 * (int'(sz) - 1 - k))) & 32'hFF, "order");
      end
      wd = sz == CMBI_SZ_QUAD ? wd : sz == CMBI_SZ_WORD ? wd & 32'hFFFF : wd & 32'hFF;
      op(2, 0, sz, x, 0, r[12] && bs == 1, 0, rd, both);
      chk(rd, wd, "exe read");
      op(1, 0, sz, 0, x, r[12] && bs == 1, 0, rd, both);
      chk(rd, wd, "fetch read");
    end
    // fetch on nvm and execution on ram together
    slow_in = 0;
    op(3, 0, CMBI_SZ_WORD, 32'h00FFB100, 32'h00000100, 0, 0, rd, both);
    chk(both, 1, "parallel buses");
    // vector block, wide and narrow peripherals, absent io address
    for (int t = 0; t < 4; t++) begin
      x = t == 0 ? 32'h4 : t == 1 ? 32'hFFFFE040 : t == 2 ? 32'hFFFFE0C1 : 32'hFFFFE180;
      bs = t == 0 ? 0 : 2;
      op(2, 1, CMBI_SZ_WORD, x, 0, 0, 32'h1234, rd, both);
      chk(acc[bs], t == 3 ? 0 : t == 2 ? 2 : 1, "io write count");
      op(2, 0, CMBI_SZ_WORD, x, 0, 0, 0, rd, both);
      chk(rd, t == 3 ? 32'hFFFF : 32'h1234, "io read");
    end
    // every bandwidth setting with dma asking all the time
    for (int f = 0; f < 4; f++) begin
      op(2, 1, CMBI_SZ_BYTE, 32'hFFFFE012, 0, 0, 32'hA8 | f, rd, both);
      chk(dma_bandwidth_select_out, f, "field write");
      op(2, 0, CMBI_SZ_WORD, 32'hFFFFE012, 0, 0, 0, rd, both);
      chk(rd, {16'h0, 6'h3F, 2'(f), 8'hFF}, "control read");
      repeat (3) op(2, 0, CMBI_SZ_WORD, 32'hFFB100, 0, 0, 0, rd, both);
      @(negedge mclk_in);
      dma_req_in = 1'b1;
      gnts = 0;
      if (f == 0) begin
        repeat (5) @(negedge mclk_in);
      end else begin
        repeat (6) op(2, 0, CMBI_SZ_WORD, 32'hFFB100, 0, 0, 0, rd, both);
        // the last op's grant rises one edge after its done pulse and is counted at the next edge
        repeat (3) @(negedge mclk_in);
      end
      dma_req_in = 1'b0;
      chk(gnts, f == 0 ? 5 : 1 + 6 / f, "grant count");
    end
    end_of_test();
  end
endmodule
